// >>> rtl/tth_burst_timer.sv
// Burst and pause timer for the transmitter
`timescale 1ns/10ps
`include "tth_defines.svh"
module tth_burst_timer (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic enable_i,
    input wire logic double_i,
    output logic tone_on_o,
    output logic done_o
);
    tth_pkg::tth_burst_e st_r;
    tth_pkg::tth_burst_e st_nxt;
    logic [`TTH_CNT_W-1:0] cnt_r;
    logic [`TTH_CNT_W-1:0] cnt_nxt;
    wire [`TTH_CNT_W-1:0] base = `TTH_CNT_W'(`TTH_BURST_CYC - 1);
    wire [`TTH_CNT_W-1:0] len = double_i ? `TTH_CNT_W'({base, 1'h1})
                                         : base;
    wire zero = (cnt_r == '0);

    // Tone, equal pause, then ready
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = zero ? cnt_r : cnt_r - 1'h1;
        case (st_r)
            tth_pkg::TTH_IDLE, tth_pkg::TTH_DONE: begin
                if (start_i) begin
                    st_nxt = tth_pkg::TTH_TONE;
                    cnt_nxt = len;
                end
            end
            tth_pkg::TTH_TONE: begin
                if (zero) begin
                    st_nxt = tth_pkg::TTH_PAUSE;
                    cnt_nxt = len;
                end
            end
            tth_pkg::TTH_PAUSE: begin
                if (zero) begin
                    st_nxt = tth_pkg::TTH_DONE;
                end
            end
            default: st_nxt = tth_pkg::TTH_IDLE;
        endcase
        if (!enable_i) begin
            st_nxt = tth_pkg::TTH_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= tth_pkg::TTH_IDLE;
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign tone_on_o = (st_r == tth_pkg::TTH_TONE);
    assign done_o = (st_r == tth_pkg::TTH_PAUSE) && zero;
endmodule

// >>> rtl/tth_bus_sense.sv
// Bus style detection and internal select generation
`timescale 1ns/10ps
`include "tth_defines.svh"
module tth_bus_sense (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic bus_strobe_input_i,
    input wire logic rw_wr_n_i,
    input wire logic register_select_line_i,
    input wire logic [3:0] data_i,
    output logic sep_strobe_o,
    output logic wr_pulse_o,
    output logic rd_pulse_o,
    output logic rd_active_o,
    output logic sel_o,
    output logic [3:0] wdata_o
);
    logic cs_d_r;
    logic sep_r;
    logic act_r;
    logic sel_r;
    logic [3:0] wd_r;
    logic wr_r;
    logic rd_r;
    wire cs_fall = cs_d_r & ~cs_n_i;
    wire cs_rise = ~cs_d_r & cs_n_i;
    // Separate-strobe when read strobe high at the edge
    wire sep_nxt = cs_fall ? bus_strobe_input_i : sep_r;
    // Access direction per style: read is strobe low or rw high
    // Style of this access, so a style change at the fall is not misread
    wire is_rd = sep_nxt ? ~bus_strobe_input_i
                         : (rw_wr_n_i & bus_strobe_input_i);
    wire is_wr = sep_nxt ? ~rw_wr_n_i : (~rw_wr_n_i & bus_strobe_input_i);

    // Latch style, select and data at the access points
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_d_r <= 1'h1;
            sep_r <= 1'h0;
            act_r <= 1'h0;
            sel_r <= 1'h0;
            wd_r <= `TTH_NIB_RST;
            wr_r <= 1'h0;
            rd_r <= 1'h0;
        end else begin
            cs_d_r <= cs_n_i;
            sep_r <= sep_nxt;
            if (cs_fall) begin
                sel_r <= register_select_line_i;
            end
            if (!cs_n_i && is_wr) begin
                wd_r <= data_i;
                wr_r <= 1'h1;
            end else if (cs_rise) begin
                wr_r <= 1'h0;
            end
            if (!cs_n_i && is_rd) begin
                rd_r <= 1'h1;
            end else if (cs_rise) begin
                rd_r <= 1'h0;
            end
            act_r <= ~cs_n_i;
        end
    end

    // One internal select for both styles; act at access end
    assign sep_strobe_o = sep_r;
    assign wr_pulse_o = cs_rise & wr_r;
    assign rd_pulse_o = cs_rise & rd_r;
    assign rd_active_o = act_r & rd_r;
    assign sel_o = sel_r;
    assign wdata_o = wd_r;
endmodule

// >>> rtl/tth_defines.svh
// Constants for the tone transceiver host port
`ifndef TTH_DEFINES_SVH
`define TTH_DEFINES_SVH
// Register select values
`define TTH_SEL_DATA 1'h0
`define TTH_SEL_CTRL 1'h1
// Primary control bits
`define TTH_CPA_TONE 0
`define TTH_CPA_CPSEL 1
`define TTH_CPA_IRQEN 2
`define TTH_CPA_SECOND 3
// Secondary control bits
`define TTH_CPB_BURSTN 0
`define TTH_CPB_TEST 1
`define TTH_CPB_SINGLE 2
`define TTH_CPB_COLUMN 3
// Status bits
`define TTH_ST_IRQ 0
`define TTH_ST_TXE 1
`define TTH_ST_RXF 2
`define TTH_ST_DSTEER 3
// Reset values
`define TTH_NIB_RST 4'h0
// Burst timing at the reference clock rate
`define TTH_CLK_HZ 50000000
`define TTH_BURST_MS 51
`define TTH_BURST_CYC ((`TTH_CLK_HZ / 1000) * `TTH_BURST_MS)
`define TTH_CNT_W 24
`endif

// >>> rtl/tth_host_port.sv
// Adaptive host port and control registers of the tone transceiver
`timescale 1ns/10ps
`include "tth_defines.svh"
module tth_host_port (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic power_down_i,
    input wire logic crystal_input_i,
    input wire logic cs_n_i,
    input wire logic bus_strobe_input_i,
    input wire logic rw_wr_n_i,
    input wire logic register_select_line_i,
    input wire logic [3:0] data_i,
    output logic [3:0] data_o,
    output logic [3:0] data_oe_o,
    input wire logic rx_valid_i,
    input wire logic [3:0] rx_code_i,
    input wire logic rx_present_i,
    input wire logic cp_square_i,
    output logic [3:0] tone_code_o,
    output logic tone_on_o,
    output logic tx_power_down_o,
    output logic single_tone_o,
    output logic column_tone_o,
    output logic call_progress_select_o,
    output logic rx_detect_inhibit_o,
    output logic test_mode_o,
    output logic crystal_clk_o,
    output logic interrupt_tone_out_pin_o,
    output logic interrupt_tone_out_pin_oe_o
);
    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    logic wr_p;
    logic rd_p;
    logic rd_act;
    logic sel;
    logic [3:0] wd;

    tth_bus_sense u_sense (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .cs_n_i(cs_n_i),
        .bus_strobe_input_i(bus_strobe_input_i),
        .rw_wr_n_i(rw_wr_n_i),
        .register_select_line_i(register_select_line_i),
        .data_i(data_i),
        .sep_strobe_o(),
        .wr_pulse_o(wr_p),
        .rd_pulse_o(rd_p),
        .rd_active_o(rd_act),
        .sel_o(sel),
        .wdata_o(wd)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    tth_pkg::tth_nib_t tx_r;
    tth_pkg::tth_nib_t rx_r;
    tth_pkg::tth_nib_t cpa_r;
    tth_pkg::tth_nib_t cpb_r;
    logic ptr_b_r;
    logic txe_r;
    logic rxf_r;
    logic dsteer_r;
    logic rxv_d_r;
    logic rxp_d_r;

    // Register decode
    wire wr_tx = wr_p & (sel == `TTH_SEL_DATA);
    wire wr_ctl = wr_p & (sel == `TTH_SEL_CTRL);
    wire rd_st = rd_p & (sel == `TTH_SEL_CTRL);
    wire wr_a = wr_ctl & ~ptr_b_r;
    wire wr_b = wr_ctl & ptr_b_r;

    // Control fields
    wire tone_en = cpa_r[`TTH_CPA_TONE];
    wire cp_mode = cpa_r[`TTH_CPA_CPSEL];
    wire irq_en = cpa_r[`TTH_CPA_IRQEN];
    wire burst = ~cpb_r[`TTH_CPB_BURSTN];

    // Receive events
    wire rx_new = rx_valid_i & ~rxv_d_r & ~cp_mode;
    wire rx_gone = ~rx_present_i & rxp_d_r;
    wire rx_came = rx_present_i & ~rxp_d_r;

    // ------------------------------------------------------------
    // Burst timer
    // ------------------------------------------------------------
    logic burst_tone;
    logic burst_done;

    tth_burst_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .start_i(wr_tx & burst),
        .enable_i(tone_en & burst & ~power_down_i),
        .double_i(cp_mode),
        .tone_on_o(burst_tone),
        .done_o(burst_done)
    );

    // Data and control register writes; pointer back to primary
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_r <= `TTH_NIB_RST;
            cpa_r <= `TTH_NIB_RST;
            cpb_r <= `TTH_NIB_RST;
            ptr_b_r <= 1'h0;
        end else if (power_down_i) begin
            ptr_b_r <= 1'h0;
        end else begin
            if (wr_tx) begin
                tx_r <= wd;
            end
            if (wr_a) begin
                cpa_r <= wd;
                ptr_b_r <= wd[`TTH_CPA_SECOND];
            end
            if (wr_b) begin
                cpb_r <= wd;
                ptr_b_r <= 1'h0;
            end
        end
    end

    // Status flags: hardware set wins over read clear
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_r <= `TTH_NIB_RST;
            txe_r <= 1'h0;
            rxf_r <= 1'h0;
            dsteer_r <= 1'h1;
            rxv_d_r <= 1'h0;
            rxp_d_r <= 1'h0;
        end else begin
            rxv_d_r <= rx_valid_i;
            rxp_d_r <= rx_present_i;
            if (rx_new) begin
                rx_r <= rx_code_i;
            end
            if (burst_done & burst) begin
                txe_r <= 1'h1;
            end else if (rd_st | ~burst) begin
                txe_r <= 1'h0;
            end
            if (rx_new) begin
                rxf_r <= 1'h1;
            end else if (rd_st) begin
                rxf_r <= 1'h0;
            end
            if (rx_gone) begin
                dsteer_r <= 1'h1;
            end else if (rx_came) begin
                dsteer_r <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data, live status, no strobe toggling needed
    // ------------------------------------------------------------
    wire st_irq = txe_r | rxf_r;
    wire [3:0] status = {dsteer_r, rxf_r, txe_r, st_irq};
    wire [3:0] rd_mux = (sel == `TTH_SEL_CTRL) ? status : rx_r;

    // Read data register, follows state while read is open
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_o <= `TTH_NIB_RST;
        end else begin
            data_o <= rd_mux;
        end
    end
    assign data_oe_o = {4{rd_act}};

    // ------------------------------------------------------------
    // Transmitter controls
    // ------------------------------------------------------------
    wire tx_run = tone_en & ~power_down_i;
    assign tone_code_o = tx_r;
    assign tone_on_o = tx_run & (burst ? burst_tone : 1'h1);
    assign tx_power_down_o = ~tx_run;
    assign single_tone_o = cpb_r[`TTH_CPB_SINGLE];
    assign column_tone_o = cpb_r[`TTH_CPB_COLUMN];
    assign test_mode_o = cpb_r[`TTH_CPB_TEST];
    assign call_progress_select_o = cp_mode;
    assign rx_detect_inhibit_o = cp_mode;
    assign crystal_clk_o = crystal_input_i;

    // ------------------------------------------------------------
    // Shared open-drain interrupt or call-progress pin
    // ------------------------------------------------------------
    wire irq_pull = irq_en & ~cp_mode & st_irq;
    wire cp_pull = irq_en & cp_mode & ~cp_square_i;
    assign interrupt_tone_out_pin_o = 1'h0;
    assign interrupt_tone_out_pin_oe_o = irq_pull | cp_pull;
endmodule

// >>> rtl/tth_pkg.sv
// Types for the tone transceiver host port
package tth_pkg;
    typedef logic [3:0] tth_nib_t;
    typedef enum logic [3:0] {
        TTH_IDLE = 4'h1,
        TTH_TONE = 4'h2,
        TTH_PAUSE = 4'h4,
        TTH_DONE = 4'h8
    } tth_burst_e;
endpackage

// >>> verif/tb_top.sv
// Self-checking testbench for the tone transceiver host port
`timescale 1ns/10ps
module tb_top;
    logic clk, nrst, pd, xtal, cs_n, stb, rw, rs, rxv, rxp, cpsq;
    logic [3:0] dw, dr, doe, rxc, code, q;
    logic ton, txpd, sng, col, cps, inh, tst, xo, pin, pin_oe;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    tth_host_port tth_host_port_i (.ref_clk_i(clk), .nrst_i(nrst),
        .power_down_i(pd), .crystal_input_i(xtal), .cs_n_i(cs_n),
        .bus_strobe_input_i(stb), .rw_wr_n_i(rw),
        .register_select_line_i(rs), .data_i(dw), .data_o(dr),
        .data_oe_o(doe), .rx_valid_i(rxv), .rx_code_i(rxc),
        .rx_present_i(rxp), .cp_square_i(cpsq), .tone_code_o(code),
        .tone_on_o(ton), .tx_power_down_o(txpd), .single_tone_o(sng),
        .column_tone_o(col), .call_progress_select_o(cps),
        .rx_detect_inhibit_o(inh), .test_mode_o(tst),
        .crystal_clk_o(xo), .interrupt_tone_out_pin_o(pin),
        .interrupt_tone_out_pin_oe_o(pin_oe));
    tth_host_model host_i (.ref_clk_i(clk), .data_o(dr), .cs_n_o(cs_n),
        .strobe_o(stb), .rw_o(rw), .rs_o(rs), .data_w_o(dw));
    // ----------------
    // Clocks and timeout
    // ----------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        xtal = 1'b0;
        forever #140 xtal = ~xtal;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_sim();
        end
    end
    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic sep, input logic r, input logic [3:0] d);
        logic [3:0] unused;
        host_i.xfer(sep, 1'b0, r, d, unused);
    endtask
    task automatic rd(input logic sep, input logic r);
        host_i.xfer(sep, 1'b1, r, 4'h0, q);
    endtask
    task automatic rx_evt(input logic [3:0] c);
        @(posedge clk);
        #1;
        rxc = c;
        rxp = 1'b1;
        rxv = 1'b1;
        @(posedge clk);
        #1;
        rxv = 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic end_sim();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        {nrst, pd, rxv, rxp, cpsq, rxc} = {5'b00001, 4'h0};
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        rd(1'b0, 1'b1);
        chk(q, 4'h8);
        wr(1, 1, 4'h0);
        wr(1, 1, 4'h0);
        wr(1, 1, 4'h8);
        wr(1, 1, 4'h0);
        rd(1'b1, 1'b1);
        chk(q, 4'h8);
        chk({3'h0, txpd}, 4'h1);
        wr(0, 1, 4'h9);
        chk({3'h0, txpd}, 4'h0);
        wr(1, 1, 4'h6);
        chk({tst, sng, col, cps}, 4'hC);
        chk({3'h0, ton}, 4'h0);
        wr(0, 0, 4'h2);
        chk({3'h0, ton}, 4'h1);
        wr(0, 1, 4'h3);
        chk({cps, inh, sng, txpd}, 4'hE);
        wr(1, 1, 4'h1);
        chk({cps, inh, sng, txpd}, 4'h2);
        wr(0, 1, 4'h9);
        wr(1, 1, 4'hD);
        chk({tst, sng, col, cps}, 4'h6);
        chk({3'h0, ton}, 4'h1);
        for (int i = 0; i < 16; i++) begin
            wr(i[0], 0, i[3:0]);
            chk(code, i[3:0]);
        end
        wr(0, 1, 4'h5);
        rx_evt(4'h5);
        chk({3'h0, pin_oe}, 4'h1);
        rd(1'b1, 1'b0);
        chk(q, 4'h5);
        rd(1'b0, 1'b1);
        chk(q, 4'h5);
        rd(1'b1, 1'b1);
        chk(q, 4'h0);
        chk({3'h0, pin_oe}, 4'h0);
        rxp = 1'b0;
        repeat (3) @(posedge clk);
        rd(1'b0, 1'b1);
        chk(q, 4'h8);
        wr(1, 1, 4'h1);
        rx_evt(4'hB);
        chk({3'h0, pin_oe}, 4'h0);
        rd(1'b0, 1'b1);
        chk(q, 4'h5);
        rd(1'b0, 1'b0);
        chk(q, 4'hB);
        wr(0, 1, 4'h7);
        cpsq = 1'b0;
        repeat (3) @(posedge clk);
        chk({3'h0, pin_oe}, 4'h1);
        #1 cpsq = 1'b1;
        repeat (3) @(posedge clk);
        chk({3'h0, pin_oe}, 4'h0);
        wr(0, 1, 4'h9);
        chk({3'h0, ton}, 4'h1);
        pd = 1'b1;
        repeat (3) @(posedge clk);
        chk({3'h0, txpd}, 4'h1);
        chk({3'h0, ton}, 4'h0);
        #1 pd = 1'b0;
        wr(0, 1, 4'h0);
        chk({3'h0, txpd}, 4'h1);
        end_sim();
    end
endmodule

// >>> verif/tth_host_model.sv
// Behavioural host processor driving the adaptive bus
`timescale 1ns/10ps
module tth_host_model (
    input wire logic ref_clk_i,
    input wire logic [3:0] data_o,
    output logic cs_n_o,
    output logic strobe_o,
    output logic rw_o,
    output logic rs_o,
    output logic [3:0] data_w_o
);
    // Idle bus levels
    initial begin
        cs_n_o = 1'b1;
        strobe_o = 1'b0;
        rw_o = 1'b1;
        rs_o = 1'b0;
        data_w_o = 4'h0;
    end
    // One access; sep=1 separate strobes, sep=0 strobe style
    task automatic xfer(input logic sep, input logic rd, input logic rs,
                        input logic [3:0] d, output logic [3:0] q);
        @(posedge ref_clk_i);
        #1;
        cs_n_o = 1'b0;
        rs_o = rs;
        strobe_o = sep;
        rw_o = sep | rd;
        data_w_o = rd ? ~data_w_o : d;
        @(posedge ref_clk_i);
        #1;
        if (!sep) begin
            strobe_o = 1'b1;
        end else if (rd) begin
            strobe_o = 1'b0;
        end else begin
            rw_o = 1'b0;
        end
        repeat (3) @(posedge ref_clk_i);
        q = data_o;
        #1;
        cs_n_o = 1'b1;
        strobe_o = sep;
        rw_o = 1'b1;
        data_w_o = ~data_w_o; // Released bus does not keep old data
        @(posedge ref_clk_i);
        #1;
    endtask
endmodule

// >>> verif/tth_host_port_props.sv
// Port-level checker for the tone transceiver host port
`timescale 1ns/10ps
module tth_host_port_props (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic power_down_i,
    input wire logic crystal_input_i,
    input wire logic cs_n_i,
    input wire logic [3:0] data_oe_o,
    input wire logic [3:0] tone_code_o,
    input wire logic tone_on_o,
    input wire logic tx_power_down_o,
    input wire logic call_progress_select_o,
    input wire logic rx_detect_inhibit_o,
    input wire logic crystal_clk_o,
    input wire logic interrupt_tone_out_pin_o
);
    // --------------------------------
    // Clocking and reset for all checks
    // --------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // --------------------------------
    // Properties
    // --------------------------------
    AST_TONE_PD: assert property (tone_on_o |-> !tx_power_down_o)
        else $error("tone on while transmitter powered down");
    AST_PD_PIN: assert property (power_down_i [*2] |-> tx_power_down_o)
        else $error("power down pin did not stop transmitter");
    AST_INHIBIT: assert property (rx_detect_inhibit_o == call_progress_select_o)
        else $error("detect inhibit does not follow call progress mode");
    AST_XTAL: assert property (crystal_clk_o == crystal_input_i)
        else $error("reference clock not passed through");
    AST_OPEN_DRAIN: assert property (interrupt_tone_out_pin_o == 1'h0)
        else $error("shared pin driven high");
    AST_OE_IDLE: assert property (cs_n_i && $past(cs_n_i) |-> data_oe_o == 4'h0)
        else $error("read data driven without select");
    AST_OE_START: assert property ($rose(data_oe_o[0]) |-> !$past(cs_n_i))
        else $error("read drive began outside an access");
    AST_CODE_HOLD: assert property ($changed(tone_code_o) |-> $past(cs_n_i, 1))
        else $error("tone code changed before access end");
endmodule
bind tth_host_port tth_host_port_props tth_host_port_props_i (.*);
